//--- logic/core_pkg.sv
/*
 * Shared constants and types for the move-based core decode, stack and lock logic.
 * Assumes a single 25 MHz clock domain and an APB register port with 32-bit data.
 */
package core_pkg;

    // Instruction word layout.
    localparam int unsigned INSTR_W       = 16;
    localparam int unsigned FORMAT_BIT    = 15;
    localparam int unsigned SRC_LSB       = 0;
    localparam int unsigned SRC_MSB       = 7;
    localparam int unsigned DST_LSB       = 8;
    localparam int unsigned DST_MSB       = 14;
    localparam int unsigned MOD_W         = 4;
    localparam int unsigned SUBIDX_W      = 3;
    localparam int unsigned IDX_W         = 5;
    localparam int unsigned PFX_BITS      = IDX_W - SUBIDX_W;
    localparam logic [3:0]  PREFIX_MODULE = 4'hB;

    // Stack geometry and reset value.
    localparam int unsigned STACK_W       = 16;
    localparam int unsigned STACK_DEPTH   = 4;
    localparam int unsigned SP_W          = 2;
    localparam logic [1:0]  SP_RESET      = 2'h3;

    // Memory system sizes and address map.
    localparam int unsigned ROM_WORDS     = 2048;
    localparam int unsigned PM_WORDS      = 1024;
    localparam int unsigned DEE_BYTES     = 128;
    localparam int unsigned SRAM_BYTES    = 64;
    localparam int unsigned PM_AW         = $clog2(PM_WORDS);
    localparam logic [15:0] ROM_BASE      = 16'h8000;
    localparam logic [15:0] ROM_LIMIT     = ROM_BASE + 16'(ROM_WORDS);
    localparam logic [15:0] APP_BASE      = 16'h0000;
    localparam logic [15:0] DATA_IN_PROG  = 16'hA000;
    localparam logic [15:0] PROG_IN_DATA  = 16'h4000;

    // Password location in physical program memory.
    localparam logic [9:0]  PW_FIRST      = 10'h010;
    localparam logic [9:0]  PW_LAST       = 10'h01F;
    localparam int unsigned PW_WORDS      = 16;

    // APB register offsets.
    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_STATUS    = 8'h04;
    localparam logic [7:0]  OFS_PW_ENTRY  = 8'h08;
    localparam logic [7:0]  OFS_ERASE     = 8'h0C;

    // Control register fields.
    localparam int unsigned CTRL_MAP_LSB  = 0;
    localparam int unsigned CTRL_PME      = 2;
    localparam int unsigned CTRL_PWL      = 3;
    localparam int unsigned CTRL_CLOCK    = 4;

    // Status and erase register fields.
    localparam int unsigned ST_SP_LSB     = 0;
    localparam int unsigned ST_UNLOCKED   = 2;
    localparam int unsigned ST_CODE_LOCK  = 3;
    localparam int unsigned ST_ACCESS     = 4;
    localparam int unsigned ST_PFX_PEND   = 5;
    localparam int unsigned ERASE_GO      = 0;

    typedef enum logic [1:0] {
        MAP_HARVARD      = 2'h0,
        MAP_DATA_IN_PROG = 2'h1,
        MAP_PROG_IN_DATA = 2'h3
    } map_mode_t;

    typedef struct packed {
        logic                src_is_reg;
        logic [7:0]          src_imm;
        logic [MOD_W-1:0]    src_module;
        logic [3:0]          src_index;
        logic [MOD_W-1:0]    dst_module;
        logic [IDX_W-1:0]    dst_index;
    } move_fields_t;

    typedef struct packed {
        logic               push;
        logic               pop;
        logic [STACK_W-1:0] data;
    } stack_req_t;

endpackage

//--- logic/ret_stack.sv
/*
 * Four-entry, 16-bit return and data stack with a two-bit pointer.
 * Assumes the caller never asks for push and pop in the same cycle; push wins if it does.
 */
`timescale 1ns/1ps
`default_nettype none
module ret_stack (
    // Clock and reset.
    input  wire logic                          clk,
    input  wire logic                          rst,
    // Stack requests.
    input  wire core_pkg::stack_req_t          req,
    // Stack state and popped value.
    output logic [core_pkg::SP_W-1:0]          stack_pointer,
    output logic [core_pkg::STACK_W-1:0]       pop_data
);
    logic [core_pkg::STACK_W-1:0] entry [core_pkg::STACK_DEPTH];
    logic [core_pkg::SP_W-1:0]    next_sp;

    // Pointer steps by one and wraps modulo four silently.
    assign next_sp = req.push ? stack_pointer + 2'h1 : stack_pointer - 2'h1;

    // Pointer update: increment before a push, decrement after a pop.
    always_ff @(posedge clk) begin
        if (rst) begin
            stack_pointer <= core_pkg::SP_RESET;
        end else if (req.push || req.pop) begin
            stack_pointer <= next_sp;
        end
    end

    // Push writes the entry the incremented pointer names.
    always_ff @(posedge clk) begin
        if (!rst && req.push) begin
            entry[next_sp] <= req.data;
        end
    end

    // Pop reads the entry at the current pointer before it moves.
    always_ff @(posedge clk) begin
        if (rst) begin
            pop_data <= 16'h0000;
        end else if (req.pop && !req.push) begin
            pop_data <= entry[stack_pointer];
        end
    end

    sp_reset_a: assert property (@(posedge clk) rst |=> stack_pointer == 2'h3)
        else $error("Stack pointer not 3 after reset.");
    push_inc_a: assert property (@(posedge clk) disable iff (rst)
        req.push |=> stack_pointer == $past(stack_pointer) + 2'h1)
        else $error("Push did not increment the pointer.");
    pop_dec_a: assert property (@(posedge clk) disable iff (rst)
        req.pop && !req.push |=> stack_pointer == $past(stack_pointer) - 2'h1)
        else $error("Pop did not decrement the pointer.");
    push_pop_a: assert property (@(posedge clk) disable iff (rst)
        req.push && !req.pop ##1 (req.pop && !req.push)
        |=> pop_data == $past(req.data, 2))
        else $error("Pop did not return the value just pushed.");
endmodule
`default_nettype wire

//--- logic/core_decode_lock.sv
/*
 * Core control: one-cycle move decode with destination prefix, return stack,
 * memory map modes, utility ROM password and code lock, and boot-mode capture.
 * Assumes program memory presents one instruction word per cycle, the debug
 * port drives the programming-mode request asynchronously, and APB is on clk.
 */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Decode each instruction in one cycle.
// - Instructions are fixed sixteen-bit words.
// - Bit fifteen selects immediate or register source.
// - Low byte carries the transfer source.
// - Source low nibble module, high nibble index.
// - Bits eight to fourteen name the destination.
// - Upper destination indexes need a prefix write.
// - Moves to designated registers trigger operations.
// - Stack is sixteen bits wide, four deep.
// - Calls, returns, interrupts, push, pop use stack.
// - Stack pointer resets to three.
// - Push increments pointer, then writes entry.
// - Pop reads entry, then decrements pointer.
// - Utility ROM starts at 8000h.
// - Harvard default plus two mapping modes.
// - Password is program words 10h to 1Fh.
// - Set password lock requires password for ROM.
// - Mass erase zeroes the password.
// - Code lock blocks all access until erase; reset also clears it.
// - Debug host sets programming mode during reset.
// - Bootloader load, dump, CRC, verify, erase.
// - ROM 2k, program 1k, data EEPROM, SRAM.
module core_decode_lock (
    // Clock and reset.
    input  wire logic                           clk,
    input  wire logic                           rst,
    // APB register port.
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [7:0]                     paddr,
    input  wire logic [31:0]                    pwdata,
    output logic [31:0]                         prdata,
    output logic                                pready,
    output logic                                pslverr,
    // Instruction fetch.
    input  wire logic                           instr_valid,
    input  wire logic [core_pkg::INSTR_W-1:0]   instr,
    output logic                                move_valid,
    output core_pkg::move_fields_t              move,
    // Stack requests from call, return, interrupt, push and pop.
    input  wire core_pkg::stack_req_t           stack_req,
    output logic [core_pkg::STACK_W-1:0]        stack_data,
    // Program memory write observation and erase.
    input  wire logic                           pm_wr_en,
    input  wire logic [core_pkg::PM_AW-1:0]     pm_wr_addr,
    input  wire logic [core_pkg::STACK_W-1:0]   pm_wr_data,
    output logic                                mass_erase,
    // Debug port requests.
    input  wire logic                           prog_mode_pin,
    input  wire logic                           dbg_req,
    output logic                                dbg_grant,
    // Memory map.
    input  wire logic [15:0]                    fetch_addr,
    output logic                                fetch_from_rom,
    output logic                                fetch_from_data,
    output logic                                data_from_prog,
    output logic [15:0]                         start_vector
);
    logic [core_pkg::STACK_W-1:0] pw_shadow [core_pkg::PW_WORDS];
    logic [core_pkg::SP_W-1:0]    stack_pointer;
    logic [1:0]                   map_sel;
    logic                         program_mode_enable;
    logic                         password_lock;
    logic                         code_lock;
    logic                         unlocked;
    logic                         pw_match;
    logic [3:0]                   pw_count;
    logic [core_pkg::PFX_BITS-1:0] destination_prefix_reg;
    logic                         prefix_pending;
    logic                         spe_meta;
    logic                         spe_sync;
    logic                         rom_access_ok;

    // Register-bus decode.
    wire        setup_phase = psel && !penable;
    wire        access_wr   = psel && penable && pwrite;
    wire        hit_ctrl    = paddr == core_pkg::OFS_CTRL;
    wire        hit_status  = paddr == core_pkg::OFS_STATUS;
    wire        hit_pw      = paddr == core_pkg::OFS_PW_ENTRY;
    wire        hit_erase   = paddr == core_pkg::OFS_ERASE;
    wire        mapped      = hit_ctrl || hit_status || hit_pw || hit_erase;
    wire        wr_ctrl     = access_wr && hit_ctrl;
    wire        wr_pw       = access_wr && hit_pw && !code_lock;
    wire        erase_go    = access_wr && hit_erase && pwdata[core_pkg::ERASE_GO];

    // Instruction field split.
    wire        fmt_reg     = instr[core_pkg::FORMAT_BIT];
    wire [7:0]  src_field   = instr[core_pkg::SRC_MSB:core_pkg::SRC_LSB];
    wire [6:0]  dst_field   = instr[core_pkg::DST_MSB:core_pkg::DST_LSB];
    wire [3:0]  dst_mod     = dst_field[core_pkg::MOD_W-1:0];
    wire [2:0]  dst_sub     = dst_field[6:core_pkg::MOD_W];
    wire        to_prefix   = instr_valid && dst_mod == core_pkg::PREFIX_MODULE;
    wire [core_pkg::PFX_BITS-1:0] pfx_used = prefix_pending ? destination_prefix_reg : '0;

    // Memory map selection from the mode field.
    wire        in_rom      = fetch_addr >= core_pkg::ROM_BASE && fetch_addr < core_pkg::ROM_LIMIT;
    wire        vn_mode     = map_sel == core_pkg::MAP_DATA_IN_PROG;
    wire        pd_mode     = map_sel == core_pkg::MAP_PROG_IN_DATA;
    wire        in_data_win = fetch_addr >= core_pkg::DATA_IN_PROG;

    // Password entry compare against the shadowed key words.
    wire        word_ok     = pwdata[15:0] == pw_shadow[pw_count];
    wire        last_word   = pw_count == 4'(core_pkg::PW_WORDS - 1);

    assign pready         = psel && penable;
    assign pslverr        = psel && penable && !mapped;
    assign rom_access_ok  = !code_lock && (!password_lock || unlocked);
    assign dbg_grant      = dbg_req && rom_access_ok;
    assign fetch_from_rom = in_rom;
    assign fetch_from_data = vn_mode && in_data_win && !in_rom;
    assign data_from_prog = pd_mode;
    assign start_vector   = program_mode_enable ? core_pkg::ROM_BASE : core_pkg::APP_BASE;

    // Two-stage synchroniser for the debug port programming request.
    always_ff @(posedge clk) begin
        spe_meta <= prog_mode_pin;
        spe_sync <= spe_meta;
    end

    // Mode bit: caught from the debug port while reset is held, cleared by software.
    always_ff @(posedge clk) begin
        if (rst) begin
            program_mode_enable <= spe_sync;
        end else if (wr_ctrl) begin
            program_mode_enable <= pwdata[core_pkg::CTRL_PME] && program_mode_enable;
        end
    end

    // Control register: map mode and password lock.
    always_ff @(posedge clk) begin
        if (rst) begin
            map_sel       <= core_pkg::MAP_HARVARD;
            password_lock <= 1'b1;
        end else if (wr_ctrl) begin
            map_sel       <= pwdata[core_pkg::CTRL_MAP_LSB +: 2];
            password_lock <= pwdata[core_pkg::CTRL_PWL];
        end
    end

    // Code lock: set by software, cleared by reset or mass erase; erase wins over a set.
    always_ff @(posedge clk) begin
        if (rst) begin
            code_lock <= 1'b0;
        end else if (erase_go) begin
            code_lock <= 1'b0;
        end else if (wr_ctrl && pwdata[core_pkg::CTRL_CLOCK]) begin
            code_lock <= 1'b1;
        end
    end

    // Mass erase pulse to the memory controller.
    always_ff @(posedge clk) begin
        if (rst) begin
            mass_erase <= 1'b0;
        end else begin
            mass_erase <= erase_go;
        end
    end

    // Key shadow follows program writes to the password words; erase zeroes it.
    genvar gi;
    generate
        for (gi = 0; gi < core_pkg::PW_WORDS; gi++) begin : g_key
            wire hit = pm_wr_en && pm_wr_addr == core_pkg::PW_FIRST + 10'(gi);
            always_ff @(posedge clk) begin
                if (rst || erase_go) begin
                    pw_shadow[gi] <= 16'h0000;
                end else if (hit) begin
                    pw_shadow[gi] <= pm_wr_data;
                end
            end
        end
    endgenerate

    // Password entry: sixteen words in order, all must match to unlock.
    always_ff @(posedge clk) begin
        if (rst || erase_go || wr_ctrl) begin
            pw_count <= 4'h0;
            pw_match <= 1'b1;
            unlocked <= 1'b0;
        end else if (wr_pw) begin
            pw_count <= pw_count + 4'h1;
            pw_match <= last_word ? 1'b1 : pw_match && word_ok;
            unlocked <= last_word ? pw_match && word_ok : 1'b0;
        end
    end

    // Read data is captured in the setup cycle and shown in the access cycle.
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (setup_phase && !pwrite) begin
            prdata <= 32'h0000_0000;
            if (hit_ctrl) begin
                prdata[core_pkg::CTRL_MAP_LSB +: 2] <= map_sel;
                prdata[core_pkg::CTRL_PME]          <= program_mode_enable;
                prdata[core_pkg::CTRL_PWL]          <= password_lock;
                prdata[core_pkg::CTRL_CLOCK]        <= code_lock;
            end else if (hit_status) begin
                prdata[core_pkg::ST_SP_LSB +: 2]    <= stack_pointer;
                prdata[core_pkg::ST_UNLOCKED]       <= unlocked;
                prdata[core_pkg::ST_CODE_LOCK]      <= code_lock;
                prdata[core_pkg::ST_ACCESS]         <= rom_access_ok;
                prdata[core_pkg::ST_PFX_PEND]       <= prefix_pending;
            end
        end
    end

    // Destination prefix: a move into the prefix module arms the next move.
    always_ff @(posedge clk) begin
        if (rst) begin
            destination_prefix_reg <= '0;
            prefix_pending         <= 1'b0;
        end else if (instr_valid) begin
            destination_prefix_reg <= src_field[core_pkg::PFX_BITS-1:0];
            prefix_pending         <= to_prefix;
        end
    end

    // Single-cycle decode of each word into the transport move fields.
    always_ff @(posedge clk) begin
        if (rst) begin
            move_valid <= 1'b0;
            move       <= '0;
        end else begin
            move_valid      <= instr_valid && !to_prefix;
            move.src_is_reg <= fmt_reg;
            move.src_imm    <= src_field;
            move.src_module <= src_field[3:0];
            move.src_index  <= src_field[7:4];
            move.dst_module <= dst_mod;
            move.dst_index  <= {pfx_used, dst_sub};
        end
    end

    ret_stack u_stack (
        .clk           (clk),
        .rst           (rst),
        .req           (stack_req),
        .stack_pointer (stack_pointer),
        .pop_data      (stack_data)
    );

    // Checks on decode, prefix, locks and bus timing.
    sequence prefix_move_s;
        instr_valid && to_prefix && src_field[1:0] == 2'h3;
    endsequence
    sequence next_move_s;
        instr_valid && !to_prefix;
    endsequence

    decode_once_a: assert property (@(posedge clk) disable iff (rst)
        next_move_s |=> move_valid && move.dst_module == $past(dst_mod))
        else $error("Move not decoded in one cycle.");
    src_format_a: assert property (@(posedge clk) disable iff (rst)
        instr_valid |=> move.src_is_reg == $past(instr[15]))
        else $error("Source format bit misdecoded.");
    prefix_use_a: assert property (@(posedge clk) disable iff (rst)
        prefix_move_s ##1 next_move_s |=> move.dst_index[4:3] == 2'h3)
        else $error("Prefix bits not applied to next destination.");
    no_prefix_a: assert property (@(posedge clk) disable iff (rst)
        (!prefix_pending and next_move_s) |=> move.dst_index[4:3] == 2'h0)
        else $error("Upper index reached without a prefix.");
    code_lock_a: assert property (@(posedge clk) disable iff (rst)
        code_lock |-> !dbg_grant)
        else $error("Access granted under code lock.");
    pwl_reset_a: assert property (@(posedge clk)
        rst ##1 !rst |-> password_lock && !dbg_grant || !dbg_req)
        else $error("Password lock not set after reset.");
    erase_key_a: assert property (@(posedge clk) disable iff (rst)
        erase_go |=> pw_shadow[0] == 16'h0000 && !code_lock ##1 mass_erase == 1'b0)
        else $error("Erase did not zero the key and clear code lock.");
    boot_vec_a: assert property (@(posedge clk)
        rst && spe_sync |=> start_vector == core_pkg::ROM_BASE)
        else $error("Programming mode did not select the ROM start.");
    apb_ready_a: assert property (@(posedge clk) disable iff (rst)
        setup_phase ##1 (psel && penable) |-> pready)
        else $error("Access phase not answered at once.");
endmodule
`default_nettype wire

//--- verification/pm_host.sv
/* Program memory writer standing in for the programming host.
   Assumes the core observes program writes on the same clock. */
`timescale 1ns/1ps
`default_nettype none
module pm_host (
    // Clock and command.
    input  wire logic        clk,
    input  wire logic        load,
    input  wire logic [15:0] key_base,
    // Program memory write port.
    output logic             pm_wr_en,
    output logic [9:0]       pm_wr_addr,
    output logic [15:0]      pm_wr_data
);
    logic [4:0] cnt = 5'h10;
    // Writes sixteen key words, one a cycle, after a load request.
    always @(posedge clk) begin
        if (load)
            cnt <= 5'h00;
        else if (!cnt[4])
            cnt <= cnt + 5'h01;
    end
    // Idle data shows the inverse pattern so stale values never match.
    assign pm_wr_en   = !cnt[4];
    assign pm_wr_addr = 10'h010 + {6'h00, cnt[3:0]};
    assign pm_wr_data = pm_wr_en ? key_base + {12'h000, cnt[3:0]} : ~key_base;
endmodule
`default_nettype wire

//--- verification/core_decode_lock_test.sv
/* Self-checking bench for the decode, stack, map and lock logic.
   Assumes zero-wait APB and the program memory writer model. */
`timescale 1ns/1ps
`default_nettype none
module core_decode_lock_test;
    typedef struct packed {
        logic [15:0]            instr;
        core_pkg::move_fields_t exp;
    } row_t;
    logic        clk, rst, psel, penable, pwrite, instr_valid, pin, dbg_req, load, slv;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, move_valid, mass_erase, dbg_grant, ffr, ffd, dfp;
    logic [15:0] instr, stack_data, fetch_addr, start_vector, pm_wr_data;
    logic        pm_wr_en;
    logic [9:0]  pm_wr_addr;
    core_pkg::move_fields_t move;
    core_pkg::stack_req_t   sreq;
    int          err_total, checks, n_erase, i;
    row_t        rows [4] = '{
        {16'h0A5C, 1'b0, 8'h5C, 4'hC, 4'h5, 4'hA, 5'h00},
        {16'hF3A7, 1'b1, 8'hA7, 4'h7, 4'hA, 4'h3, 5'h07},
        {16'h8100, 1'b1, 8'h00, 4'h0, 4'h0, 4'h1, 5'h00},
        {16'h7FFF, 1'b0, 8'hFF, 4'hF, 4'hF, 4'hF, 5'h07}};
    logic [1:0]  modes [3] = '{2'h0, 2'h1, 2'h3};
    logic [16:0] roms [4] = '{17'h0FFFF, 17'h18000, 17'h187FF, 17'h08800};

    core_decode_lock core_decode_lock_i (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .instr_valid(instr_valid),
        .instr(instr), .move_valid(move_valid), .move(move), .stack_req(sreq),
        .stack_data(stack_data), .pm_wr_en(pm_wr_en), .pm_wr_addr(pm_wr_addr),
        .pm_wr_data(pm_wr_data), .mass_erase(mass_erase), .prog_mode_pin(pin),
        .dbg_req(dbg_req), .dbg_grant(dbg_grant), .fetch_addr(fetch_addr),
        .fetch_from_rom(ffr), .fetch_from_data(ffd), .data_from_prog(dfp),
        .start_vector(start_vector));
    pm_host pm_host_i (.clk(clk), .load(load), .key_base(16'h5A30),
        .pm_wr_en(pm_wr_en), .pm_wr_addr(pm_wr_addr), .pm_wr_data(pm_wr_data));

    // Clock, erase pulse counter and hang watchdog.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) if (mass_erase === 1'b1) n_erase++;
    initial begin
        repeat (4000) @(posedge clk);
        err_total++;
        stop_test();
    end

    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        if (err_total == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // One APB transfer, held until pready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) err_total++;
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Enters fifteen key words base, base+step, ... and then the last word.
    task automatic key(input logic [15:0] base, input logic [15:0] step,
                       input logic [15:0] last);
        for (int j = 0; j < 15; j++) apb(1'b1, core_pkg::OFS_PW_ENTRY, base + 16'(j) * step);
        apb(1'b1, core_pkg::OFS_PW_ENTRY, last);
        apb(1'b0, core_pkg::OFS_STATUS, 32'h0);
    endtask
    task automatic chk_move(input core_pkg::move_fields_t e);
        @(negedge clk);
        chk(move_valid, 1'b1);
        chk(move.src_is_reg, e.src_is_reg);
        if (e.src_is_reg) begin
            chk(move.src_module, e.src_module);
            chk(move.src_index, e.src_index);
        end else
            chk(move.src_imm, e.src_imm);
        chk(move.dst_module, e.dst_module);
        chk(move.dst_index, e.dst_index);
    endtask

    // Main sequence: reset, a prefix case, decode rows, then hand-written cases.
    initial begin
        {rst, psel, penable, pwrite, instr_valid, pin, dbg_req, load} = 8'h80;
        {paddr, pwdata, instr, fetch_addr, sreq} = '0;
        {err_total, checks, n_erase} = '0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, core_pkg::OFS_STATUS, 32'h0);
        chk(rd[1:0], 2'h3);
        chk({stack_data, start_vector}, 32'h0);
        chk(move_valid, 1'b0);
        // Prefix word, then a move that takes its bits, then plain rows.
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= 16'h0B03;
        @(posedge clk);
        instr <= 16'h1A42;
        @(negedge clk);
        chk(move_valid, 1'b0);
        @(posedge clk);
        instr_valid <= 1'b0;
        chk_move({1'b0, 8'h42, 4'h2, 4'h4, 4'hA, 5'h19});
        for (i = 0; i < 4; i++) begin
            @(posedge clk);
            instr_valid <= 1'b1;
            instr <= rows[i].instr;
            @(posedge clk);
            instr_valid <= 1'b0;
            chk_move(rows[i].exp);
        end
        // Five pushes wrap the pointer; pops read then step down.
        @(posedge clk);
        for (i = 0; i < 5; i++) begin
            sreq <= '{push: 1'b1, pop: 1'b0, data: 16'hC000 + 16'(i)};
            @(posedge clk);
        end
        sreq <= '{push: 1'b0, pop: 1'b1, data: 16'h0000};
        @(posedge clk);
        @(negedge clk);
        chk(stack_data, 16'hC004);
        @(posedge clk);
        sreq <= '0;
        @(negedge clk);
        chk(stack_data, 16'hC003);
        apb(1'b0, core_pkg::OFS_STATUS, 32'h0);
        chk(rd[1:0], 2'h2);
        apb(1'b0, 8'h10, 32'h0);
        chk(slv, 1'b1);
        chk(rd, 32'h0);
        // Password lock: locked, good key, bad key, lock cleared.
        dbg_req <= 1'b1;
        load <= 1'b1;
        @(posedge clk);
        load <= 1'b0;
        chk(dbg_grant, 1'b0);
        repeat (18) @(posedge clk);
        key(16'h5A30, 16'h0001, 16'h5A3F);
        chk(rd[2], 1'b1);
        @(negedge clk);
        chk(dbg_grant, 1'b1);
        apb(1'b1, core_pkg::OFS_CTRL, 32'h8);
        key(16'h5A30, 16'h0001, 16'h5A40);
        chk({rd[2], dbg_grant}, 2'h0);
        for (i = 0; i < 3; i++) begin
            apb(1'b1, core_pkg::OFS_CTRL, {30'h0, modes[i]});
            fetch_addr <= 16'hA000;
            @(negedge clk);
            chk({ffd, dfp, dbg_grant}, {modes[i] == 2'h1, modes[i] == 2'h3, 1'b1});
        end
        apb(1'b1, core_pkg::OFS_CTRL, 32'h0);
        for (i = 0; i < 4; i++) begin
            fetch_addr <= roms[i][15:0];
            @(negedge clk);
            chk(ffr, roms[i][16]);
        end
        // Code lock beats a cleared lock bit and the key; erase clears it.
        apb(1'b1, core_pkg::OFS_CTRL, 32'h10);
        key(16'h5A30, 16'h0001, 16'h5A3F);
        chk({rd[3], dbg_grant}, 2'h2);
        apb(1'b1, core_pkg::OFS_ERASE, 32'h1);
        repeat (3) @(posedge clk);
        chk(n_erase, 1);
        apb(1'b1, core_pkg::OFS_CTRL, 32'h8);
        key(16'h0000, 16'h0000, 16'h0000);
        chk({rd[3:2], dbg_grant}, 3'h3);
        // Programming mode captured during a second reset.
        @(posedge clk);
        pin <= 1'b1;
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        pin <= 1'b0;
        @(negedge clk);
        chk(start_vector, 16'h8000);
        apb(1'b0, core_pkg::OFS_CTRL, 32'h0);
        chk(rd[2], 1'b1);
        apb(1'b1, core_pkg::OFS_CTRL, 32'h8);
        @(negedge clk);
        chk(start_vector, 16'h0000);
        stop_test();
    end
endmodule
`default_nettype wire
